// file: ctp_pkg.sv
package ctp_pkg;
  // structure
  localparam int         UNITS        = 2;
  localparam int         BYTE_W       = 8;
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 32;
  // register map, one aligned word each
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PERIOD   = 8'h04;
  localparam logic [7:0] OFS_DUTY     = 8'h08;
  localparam logic [7:0] UNIT_STRIDE  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  // control register fields
  localparam int         RUN_BIT      = 3;
  localparam int         FLOP_BIT     = 7;
  localparam int         MODE_LSB     = 0;
  localparam int         MODE_MSB     = 2;
  localparam int         CLKSEL_LSB   = 4;
  localparam int         CLKSEL_MSB   = 6;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // operating modes (low three control bits)
  localparam logic [2:0] MODE_TIMER8  = 3'h0;
  localparam logic [2:0] MODE_PDO     = 3'h1;
  localparam logic [2:0] MODE_PWM8    = 3'h2;
  localparam logic [2:0] MODE_T16_LOW = 3'h3;
  localparam logic [2:0] MODE_T16_UP  = 3'h4;
  // source clock select codes
  localparam int         NUM_CLKSEL   = 8;
  localparam int         CLK_SLOW     = 0;
  localparam int         CLK_DIV7     = 1;
  localparam int         CLK_DIV5     = 2;
  localparam int         CLK_DIV3     = 3;
  localparam int         CLK_FS       = 4;
  localparam int         CLK_HALF     = 5;
  localparam int         CLK_FULL     = 6;
  localparam int         CLK_NONE     = 7;
  // divider exponents of the system clock
  localparam int         PRE_W        = 11;
  localparam int         EXP_DIV7     = 7;
  localparam int         EXP_DIV5     = 5;
  localparam int         EXP_DIV3     = 3;
  localparam int         FS_DIV_W     = 3;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [7:0] CNT_ZERO     = 8'h00;
endpackage

// file: ctp_prescaler.sv
`timescale 1ns/1ps
// divides the system clock and the slow oscillator into one-cycle enables
module ctp_prescaler (
  input  wire logic                            sys_clk,
  input  wire logic                            rstn,
  input  wire logic                            lowFreqOsc,
  input  wire logic                            slowPrescaleSelect,
  output logic [ctp_pkg::NUM_CLKSEL-1:0]       clkEn
);
  logic [ctp_pkg::PRE_W-1:0]    preReg;
  logic [ctp_pkg::PRE_W-1:0]    preNext;
  logic [ctp_pkg::FS_DIV_W-1:0] fsDivReg;
  logic [ctp_pkg::FS_DIV_W-1:0] fsDivNext;
  logic                         fsMetaReg;
  logic                         fsSyncReg;
  logic                         fsLastReg;
  logic                         fsPulse;

  // slow oscillator edge becomes a pulse; first stage feeds only the second
  always_comb begin
    preNext   = preReg + 1'b1;
    fsPulse   = fsSyncReg & ~fsLastReg;
    fsDivNext = fsPulse ? fsDivReg + 1'b1 : fsDivReg;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      preReg    <= '0;
      fsDivReg  <= '0;
      fsMetaReg <= 1'b0;
      fsSyncReg <= 1'b0;
      fsLastReg <= 1'b0;
    end else begin
      preReg    <= preNext;
      fsDivReg  <= fsDivNext;
      fsMetaReg <= lowFreqOsc;
      fsSyncReg <= fsMetaReg;
      fsLastReg <= fsSyncReg;
    end
  end

  // a power-of-two rate fires when the low counter bits are all ones
  always_comb begin
    clkEn                     = '0;
    clkEn[ctp_pkg::CLK_SLOW]  = slowPrescaleSelect ? (fsPulse & (&fsDivReg))
                                                   : (&preReg);
    clkEn[ctp_pkg::CLK_DIV7]  = &preReg[ctp_pkg::EXP_DIV7-1:0];
    clkEn[ctp_pkg::CLK_DIV5]  = &preReg[ctp_pkg::EXP_DIV5-1:0];
    clkEn[ctp_pkg::CLK_DIV3]  = &preReg[ctp_pkg::EXP_DIV3-1:0];
    clkEn[ctp_pkg::CLK_FS]    = fsPulse;
    clkEn[ctp_pkg::CLK_HALF]  = preReg[0];
    clkEn[ctp_pkg::CLK_FULL]  = 1'b1;
    clkEn[ctp_pkg::CLK_NONE]  = 1'b0;
  end
endmodule

// file: ctp_timer_pair.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ctp_timer_pair (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ctp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ctp_pkg::DATA_W-1:0]  pwdata,
  output logic [ctp_pkg::DATA_W-1:0]       prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        lowFreqOsc,
  input  wire logic                        slowPrescaleSelect,
  output logic [ctp_pkg::UNITS-1:0]        unitMatchIrq,
  output logic [ctp_pkg::UNITS-1:0]        dividerOutPinN,
  output logic [ctp_pkg::UNITS-1:0]        modulatedOutPinN
);
  localparam int U = ctp_pkg::UNITS;
  localparam int B = ctp_pkg::BYTE_W;

  logic [B-1:0]                  ctrlReg   [U];
  logic [B-1:0]                  ctrlNext  [U];
  logic [B-1:0]                  perReg    [U];
  logic [B-1:0]                  perNext   [U];
  logic [B-1:0]                  dutyReg   [U];
  logic [B-1:0]                  dutyNext  [U];
  logic [B-1:0]                  holdReg   [U];
  logic [B-1:0]                  holdNext  [U];
  logic [B-1:0]                  cntReg    [U];
  logic [B-1:0]                  cntNext   [U];
  logic [U-1:0]                  flopReg;
  logic [U-1:0]                  flopNext;
  logic [U-1:0]                  irqReg;
  logic [U-1:0]                  irqNext;
  logic [ctp_pkg::DATA_W-1:0]    rdReg;
  logic [ctp_pkg::DATA_W-1:0]    rdNext;
  logic [ctp_pkg::NUM_CLKSEL-1:0] clkEn;
  logic [U-1:0]                  tick;
  logic [U-1:0]                  effRun;
  logic [U-1:0]                  ctrlWr;
  logic [U-1:0]                  perWr;
  logic [U-1:0]                  dutyWr;
  logic [U-1:0]                  ctrlRd;
  logic [U-1:0]                  perRd;
  logic [U-1:0]                  dutyRd;
  logic [2:0]                    mode      [U];
  logic                          cascade;
  logic                          wrAcc;
  logic                          setup;
  logic                          hit;
  logic [2*B-1:0]                fullInc;

  ctp_prescaler u_prescaler (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .lowFreqOsc         (lowFreqOsc),
    .slowPrescaleSelect (slowPrescaleSelect),
    .clkEn              (clkEn)
  );

  // bus phases: zero wait states, so pready is a constant high
  assign wrAcc   = psel & penable & pwrite;
  assign setup   = psel & ~penable;
  assign pready  = 1'b1;
  assign cascade = (ctrlReg[1][ctp_pkg::MODE_MSB:ctp_pkg::MODE_LSB]
                    == ctp_pkg::MODE_T16_UP);
  assign fullInc = {cntReg[1], cntReg[0]} + 16'h0001;

  // per-unit decode; in 16-bit mode both halves follow the lower clock
  // and the upper run bit
  genvar g;
  generate
    for (g = 0; g < U; g = g + 1) begin : g_unit
      localparam logic [7:0] BASE = 8'(g) * ctp_pkg::UNIT_STRIDE;
      assign mode[g]   = ctrlReg[g][ctp_pkg::MODE_MSB:ctp_pkg::MODE_LSB];
      assign tick[g]   = cascade
        ? clkEn[ctrlReg[0][ctp_pkg::CLKSEL_MSB:ctp_pkg::CLKSEL_LSB]]
        : clkEn[ctrlReg[g][ctp_pkg::CLKSEL_MSB:ctp_pkg::CLKSEL_LSB]];
      assign effRun[g] = cascade ? ctrlReg[1][ctp_pkg::RUN_BIT]
                                 : ctrlReg[g][ctp_pkg::RUN_BIT];
      assign ctrlRd[g] = (paddr == BASE + ctp_pkg::OFS_CTRL);
      assign perRd[g]  = (paddr == BASE + ctp_pkg::OFS_PERIOD);
      assign dutyRd[g] = (paddr == BASE + ctp_pkg::OFS_DUTY);
      assign ctrlWr[g] = wrAcc & ctrlRd[g];
      assign perWr[g]  = wrAcc & perRd[g];
      assign dutyWr[g] = wrAcc & dutyRd[g];
      assign dividerOutPinN[g]   = ~flopReg[g];
      assign modulatedOutPinN[g] = ~flopReg[g];
    end
  endgenerate

  // counting, compare and bus writes; bus writes are applied last
  always_comb begin
    for (int u = 0; u < U; u++) begin
      ctrlNext[u] = ctrlReg[u];
      perNext[u]  = perReg[u];
      dutyNext[u] = dutyReg[u];
      holdNext[u] = holdReg[u];
      cntNext[u]  = cntReg[u];
    end
    flopNext = flopReg;
    irqNext  = '0;
    if (cascade) begin
      if (effRun[1] && tick[0]) begin
        if (fullInc == {perReg[1], perReg[0]}) begin
          cntNext[0] = ctp_pkg::CNT_ZERO;
          cntNext[1] = ctp_pkg::CNT_ZERO;
          irqNext[1] = 1'b1;
        end else begin
          cntNext[0] = fullInc[B-1:0];
          cntNext[1] = fullInc[2*B-1:B];
        end
      end else if (!effRun[1]) begin
        cntNext[0] = ctp_pkg::CNT_ZERO;
        cntNext[1] = ctp_pkg::CNT_ZERO;
      end
    end else begin
      for (int u = 0; u < U; u++) begin
        if (!effRun[u]) begin
          // stopped: counter clears, flop keeps the pin level
          cntNext[u] = ctp_pkg::CNT_ZERO;
        end else if (tick[u] && mode[u] == ctp_pkg::MODE_PWM8) begin
          if (cntReg[u] == ctp_pkg::CNT_MAX) begin
            cntNext[u]  = ctp_pkg::CNT_ZERO;
            flopNext[u] = ~flopReg[u];
            irqNext[u]  = 1'b1;
            dutyNext[u] = holdReg[u];
          end else begin
            cntNext[u] = cntReg[u] + 8'h01;
            if (cntReg[u] + 8'h01 == dutyReg[u]) begin
              flopNext[u] = ~flopReg[u];
            end
          end
        end else if (tick[u]) begin
          if (cntReg[u] + 8'h01 == perReg[u]) begin
            cntNext[u] = ctp_pkg::CNT_ZERO;
            irqNext[u] = 1'b1;
            if (mode[u] == ctp_pkg::MODE_PDO) begin
              flopNext[u] = ~flopReg[u];
            end
          end else begin
            cntNext[u] = cntReg[u] + 8'h01;
          end
        end
      end
    end
    for (int u = 0; u < U; u++) begin
      if (ctrlWr[u]) begin
        ctrlNext[u] = pwdata[B-1:0];
        // flop loads only while stopped, so a stop write leaves the pin
        if (!ctrlReg[u][ctp_pkg::RUN_BIT]) begin
          flopNext[u] = pwdata[ctp_pkg::FLOP_BIT];
        end
      end
      if (perWr[u]) begin
        perNext[u] = pwdata[B-1:0];
      end
      if (dutyWr[u]) begin
        // a write in the transfer cycle lands in hold; old hold goes live
        holdNext[u] = pwdata[B-1:0];
        if (!effRun[u]) begin
          dutyNext[u] = pwdata[B-1:0];
        end
      end
    end
  end

  // read data captured in the setup phase, valid through the access
  always_comb begin
    rdNext = rdReg;
    hit    = (paddr == ctp_pkg::OFS_STATUS);
    for (int u = 0; u < U; u++) begin
      hit = hit | ctrlRd[u] | perRd[u] | dutyRd[u];
    end
    if (setup) begin
      rdNext = '0;
      if (paddr == ctp_pkg::OFS_STATUS) begin
        rdNext[2*B+U-1:0] = {flopReg, cntReg[1], cntReg[0]};
      end
      for (int u = 0; u < U; u++) begin
        if (ctrlRd[u]) rdNext[B-1:0] = ctrlReg[u];
        if (perRd[u])  rdNext[B-1:0] = perReg[u];
        if (dutyRd[u]) rdNext[B-1:0] = dutyReg[u];
      end
    end
  end

  assign prdata       = rdReg;
  assign pslverr      = psel & penable & ~hit;
  assign unitMatchIrq = irqReg;

  // all state registers; reset clears the output flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int u = 0; u < U; u++) begin
        ctrlReg[u] <= ctp_pkg::CTRL_RESET;
        perReg[u]  <= ctp_pkg::REG_RESET;
        dutyReg[u] <= ctp_pkg::REG_RESET;
        holdReg[u] <= ctp_pkg::REG_RESET;
        cntReg[u]  <= ctp_pkg::CNT_ZERO;
      end
      flopReg <= '0;
      irqReg  <= '0;
      rdReg   <= '0;
    end else begin
      for (int u = 0; u < U; u++) begin
        ctrlReg[u] <= ctrlNext[u];
        perReg[u]  <= perNext[u];
        dutyReg[u] <= dutyNext[u];
        holdReg[u] <= holdNext[u];
        cntReg[u]  <= cntNext[u];
      end
      flopReg <= flopNext;
      irqReg  <= irqNext;
      rdReg   <= rdNext;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // one unit stepping in a given mode, no control write in the way
  sequence s_step(int k, logic [2:0] m);
    !cascade && effRun[k] && tick[k] && mode[k] == m && !ctrlWr[k];
  endsequence

  a_pdo_match_toggle: assert property (
    s_step(1, ctp_pkg::MODE_PDO) ##0 (cntReg[1] + 8'h01 == perReg[1])
    |=> flopReg[1] != $past(flopReg[1]) && cntReg[1] == 8'h00
        && unitMatchIrq[1])
    else $error("divider match did not toggle and clear");

  a_pwm_duty_toggle: assert property (
    s_step(0, ctp_pkg::MODE_PWM8) ##0 (cntReg[0] != 8'hFF)
    ##0 (cntReg[0] + 8'h01 == dutyReg[0])
    |=> flopReg[0] != $past(flopReg[0]) && cntReg[0] != 8'h00
        && !unitMatchIrq[0])
    else $error("pwm duty match wrong");

  a_pwm_overflow: assert property (
    s_step(0, ctp_pkg::MODE_PWM8) ##0 (cntReg[0] == 8'hFF)
    |=> flopReg[0] != $past(flopReg[0]) && cntReg[0] == 8'h00
        && unitMatchIrq[0] && dutyReg[0] == $past(holdReg[0]))
    else $error("pwm overflow wrong");

  a_stop_holds: assert property (
    !effRun[0] && !ctrlWr[0] |=> $stable(modulatedOutPinN[0]))
    else $error("pwm pin moved while stopped");

  a_stop_holds_up: assert property (
    !effRun[1] && !ctrlWr[1] |=> $stable(dividerOutPinN[1]))
    else $error("divider pin moved while stopped");

  a_flop_load: assert property (
    ctrlWr[0] && !ctrlReg[0][ctp_pkg::RUN_BIT]
    |=> modulatedOutPinN[0] == !$past(pwdata[ctp_pkg::FLOP_BIT]))
    else $error("flop not loaded from control");

  a_duty_held: assert property (
    dutyWr[0] && effRun[0] && !irqNext[0] |=> $stable(dutyReg[0]) ##1 1'b1)
    else $error("duty went live before transfer");

  a_duty_direct: assert property (
    dutyWr[0] && !effRun[0] |=> dutyReg[0] == $past(pwdata[7:0]))
    else $error("stopped duty write not applied");

  a_cascade_match: assert property (
    cascade && effRun[1] && tick[0] && fullInc == {perReg[1], perReg[0]}
    |=> cntReg[0] == 8'h00 && cntReg[1] == 8'h00 && unitMatchIrq == 2'b10)
    else $error("16-bit match wrong");

  a_cascade_carry: assert property (
    cascade && effRun[1] && tick[0] && cntReg[0] == 8'hFF
    && fullInc != {perReg[1], perReg[0]}
    |=> cntReg[1] == $past(cntReg[1]) + 8'h01 && cntReg[0] == 8'h00)
    else $error("lower overflow did not carry");
endmodule

// file: ctp_timer_pair_tb.sv
`timescale 1ns/1ps
module ctp_timer_pair_tb;
  logic        sys_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lowFreqOsc;
  logic        slowPrescaleSelect;
  logic [1:0]  unitMatchIrq;
  logic [1:0]  dividerOutPinN;
  logic [1:0]  modulatedOutPinN;
  int          fails;
  int          compares;
  int          cycles;
  int          n;
  int          low;
  int          lowPre;
  logic [7:0]  rnd;
  logic [7:0]  dOld;
  logic [7:0]  dNew;
  logic [31:0] rd;
  logic        err;
  logic        pinA;
  logic        pinB;

  ctp_timer_pair dut_u (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .lowFreqOsc         (lowFreqOsc),
    .slowPrescaleSelect (slowPrescaleSelect),
    .unitMatchIrq       (unitMatchIrq),
    .dividerOutPinN     (dividerOutPinN),
    .modulatedOutPinN   (modulatedOutPinN)
  );

  // clock, and a slow oscillator unrelated to the counters under test
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles % 16 == 0) lowFreqOsc <= ~lowFreqOsc;
    if (cycles == 60000) begin
      fails = fails + 1;
      end_of_test();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // duty window: corners kept above the apb latency after an irq
  function automatic logic [7:0] pick_duty(input logic [7:0] r);
    return 8'(16 + (r % 239));
  endfunction

  function automatic int pwm_low(input logic [7:0] d);
    return 256 - int'(d);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rw(input int u, input logic [7:0] ofs, input logic [7:0] v);
    apb(1'b1, 8'(ctp_pkg::UNIT_STRIDE * u) + ofs, {24'h0, v});
  endtask

  task automatic rr(input int u, input logic [7:0] ofs);
    apb(1'b0, 8'(ctp_pkg::UNIT_STRIDE * u) + ofs, 32'h0);
  endtask

  // waits for an irq pulse, then spans one full period to the next
  task automatic measure(input int u);
    int w;
    w = 0;
    lowPre = 0;
    do begin
      @(negedge sys_clk);
      w++;
      if (modulatedOutPinN[u] === 1'b0) lowPre++;
    end while (unitMatchIrq[u] !== 1'b1 && w < 5000);
    pinA = dividerOutPinN[u];
    n = 0;
    low = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (modulatedOutPinN[u] === 1'b0) low++;
    end while (unitMatchIrq[u] !== 1'b1 && n < 5000);
    pinB = dividerOutPinN[u];
  endtask

  // stop, pins must hold; then a separate flop write moves them
  task automatic hold_check(input int u, input logic [7:0] c);
    logic p;
    rw(u, ctp_pkg::OFS_CTRL, c);
    @(negedge sys_clk);
    p = dividerOutPinN[u];
    repeat (20) @(negedge sys_clk);
    chk("held pins", {30'h0, p, p},
        {30'h0, dividerOutPinN[u], modulatedOutPinN[u]});
    rw(u, ctp_pkg::OFS_CTRL, c | 8'h80);
    @(negedge sys_clk);
    chk("flop set pins", 32'h0,
        {30'h0, dividerOutPinN[u], modulatedOutPinN[u]});
    rw(u, ctp_pkg::OFS_CTRL, c);
    @(negedge sys_clk);
    chk("flop clear pins", 32'h3,
        {30'h0, dividerOutPinN[u], modulatedOutPinN[u]});
  endtask

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lowFreqOsc = 1'b0;
    slowPrescaleSelect = 1'b0;
    fails = 0;
    compares = 0;
    cycles = 0;
    rnd = 8'h1D;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    // reset values of every unit register and of the pins
    for (int u = 0; u < 2; u++) begin
      for (int k = 0; k < 3; k++) begin
        rr(u, 8'(4 * k));
        chk("reset reg", 32'h0, rd);
      end
    end
    chk("reset pins", 32'hF, {28'h0, dividerOutPinN, modulatedOutPinN});
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test reset done");
    // divider output on the upper unit at high_freq_osc/2^7
    rw(1, ctp_pkg::OFS_PERIOD, 8'h02);
    rw(1, ctp_pkg::OFS_CTRL, 8'h11);
    rw(1, ctp_pkg::OFS_CTRL, 8'h19);
    measure(1);
    chk("pdo interval", 32'd256, n);
    chk("pdo toggle", {31'h0, ~pinA}, {31'h0, pinB});
    rw(1, ctp_pkg::OFS_PERIOD, 8'h03);
    measure(1);
    measure(1);
    chk("pdo new period", 32'd384, n);
    hold_check(1, 8'h11);
    $display("test divider done");
    // pwm on the lower unit, every-cycle clock: 256 counts a frame
    dOld = pick_duty(rnd);
    rw(0, ctp_pkg::OFS_DUTY, dOld);
    rr(0, ctp_pkg::OFS_DUTY);
    chk("stopped duty", {24'h0, dOld}, rd);
    rw(0, ctp_pkg::OFS_CTRL, 8'h6A);
    measure(0);
    chk("pwm frame", 32'd256, n);
    chk("pwm low", pwm_low(dOld), low);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      dNew = (i == 3) ? 8'hFE : pick_duty(rnd);
      rw(0, ctp_pkg::OFS_DUTY, dNew);
      rr(0, ctp_pkg::OFS_DUTY);
      chk("duty readback", {24'h0, dOld}, rd);
      measure(0);
      chk("held duty low", pwm_low(dOld), lowPre);
      chk("new duty low", pwm_low(dNew), low);
      rr(0, ctp_pkg::OFS_DUTY);
      chk("duty after irq", {24'h0, dNew}, rd);
      dOld = dNew;
    end
    hold_check(0, 8'h62);
    $display("test pwm done");
    // plain timer on the lower unit, half-rate clock, random period
    rnd = lfsr(rnd);
    rw(0, ctp_pkg::OFS_PERIOD, rnd | 8'h01);
    rw(0, ctp_pkg::OFS_CTRL, 8'h50);
    rw(0, ctp_pkg::OFS_CTRL, 8'h58);
    measure(0);
    chk("timer interval", {23'h0, rnd | 8'h01, 1'b0}, n);
    chk("timer pins", 32'h3,
        {30'h0, dividerOutPinN[0], modulatedOutPinN[0]});
    $display("test timer done");
    // cascaded 16-bit timer, first with the documented codes
    rw(0, ctp_pkg::OFS_PERIOD, 8'h02);
    rw(1, ctp_pkg::OFS_PERIOD, 8'h00);
    rw(0, ctp_pkg::OFS_CTRL, 8'h13);
    rw(1, ctp_pkg::OFS_CTRL, 8'h04);
    rw(1, ctp_pkg::OFS_CTRL, 8'h0C);
    measure(1);
    chk("t16 interval", 32'd256, n);
    rw(0, ctp_pkg::OFS_CTRL, 8'h63);
    rw(0, ctp_pkg::OFS_PERIOD, 8'h2C);
    rw(1, ctp_pkg::OFS_PERIOD, 8'h01);
    measure(1);
    measure(1);
    chk("t16 wide period", 32'd300, n);
    $display("test cascade done");
    end_of_test();
  end
endmodule
